// ==== verilog/mprc_pkg.sv ====
// Package of constants and types shared by both ends of the modem power route control.
package mprc_pkg;

   // ----------------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------------
   localparam int unsigned CLK_HZ          = 50_000_000;
   localparam int unsigned HOST_BOOT_US    = 20;
   localparam int unsigned HOST_BOOT_CYC   = (HOST_BOOT_US * (CLK_HZ / 1_000_000));
   localparam int unsigned BOOT_CNT_W      = 16;

   // ----------------------------------------------------------------------
   // Register map of the device end
   // ----------------------------------------------------------------------
   localparam logic [11:0] CTRL_OFS        = 12'h000;
   localparam logic [11:0] STATUS_OFS      = 12'h004;
   localparam int unsigned CTRL_MODEM_EN   = 0;
   localparam int unsigned CTRL_BOOT_SEL   = 1;
   localparam int unsigned CTRL_ROUTE_LSB  = 2;
   localparam int unsigned CTRL_BOOT_GO    = 4;
   localparam int unsigned CTRL_HOST_OFF   = 5;
   localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
   localparam int unsigned STAT_HOST_ON    = 0;
   localparam int unsigned STAT_POWER_GOOD = 1;
   localparam int unsigned STAT_MODEM_PWR  = 2;
   localparam int unsigned STAT_SEL_LSB    = 3;
   localparam int unsigned STAT_BOOT_LSB   = 6;

   // ----------------------------------------------------------------------
   // Routing select port bits
   // ----------------------------------------------------------------------
   localparam int unsigned SEL_MICRO_HOST_BIT  = 2;
   localparam int unsigned SEL_MODEM_MICRO_BIT = 3;
   localparam int unsigned SEL_MODEM_HOST_BIT  = 4;

   // ----------------------------------------------------------------------
   // Fixed addresses and settings used by the far side
   // ----------------------------------------------------------------------
   localparam logic [6:0]  I2C_ADDR_MON_5V     = 7'h45; // R10
   localparam logic [6:0]  I2C_ADDR_MON_BOOST  = 7'h46; // R10
   localparam logic [6:0]  I2C_ADDR_MON_GPS    = 7'h47; // R10
   localparam logic [6:0]  I2C_ADDR_MON_PREREG = 7'h48; // R11
   localparam logic [6:0]  I2C_ADDR_GPS        = 7'h21; // R11
   localparam logic [15:0] CAL_MON_5V          = 16'h001F; // R12
   localparam logic [15:0] CAL_MON_BOOST       = 16'h001F; // R12
   localparam logic [15:0] CAL_MON_GPS         = 16'h0400; // R12
   localparam int unsigned BAUD_GPS            = 9600; // R13
   localparam int unsigned BAUD_MODEM          = 19200; // R13

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      ROUTE_NONE        = 2'b00,
      ROUTE_MICRO_HOST  = 2'b01,
      ROUTE_MODEM_MICRO = 2'b10,
      ROUTE_MODEM_HOST  = 2'b11
   } mprc_route_t;

   typedef enum logic [1:0] {
      BOOT_IDLE  = 2'b00,
      BOOT_ROUTE = 2'b01,
      BOOT_WAIT  = 2'b10,
      BOOT_RUN   = 2'b11
   } mprc_boot_t;

   typedef enum logic [1:0] {
      HOST_OFF     = 2'b00,
      HOST_START   = 2'b01,
      HOST_RUNNING = 2'b10
   } mprc_host_t;

endpackage : mprc_pkg

// ==== verilog/mprc_link_if.sv ====
// Interface joining the module controller end and the host computer end.
`timescale 1ns/1ps
interface mprc_link_if;
   logic host_power_on;
   logic boot_sel;
   logic host_power_good;
   logic host_status_on;
   logic host_modem_en;
   logic sel_micro_host;
   logic sel_modem_micro;
   logic sel_modem_host;

   modport dev (
      output host_power_on,
      output boot_sel,
      output sel_micro_host,
      output sel_modem_micro,
      output sel_modem_host,
      input  host_power_good,
      input  host_status_on,
      input  host_modem_en
   );

   modport host (
      input  host_power_on,
      input  boot_sel,
      input  sel_micro_host,
      input  sel_modem_micro,
      input  sel_modem_host,
      output host_power_good,
      output host_status_on,
      output host_modem_en
   );
endinterface : mprc_link_if

// ==== verilog/mprc_sync.sv ====
// Two flip-flop synchroniser for a group of levels.
`timescale 1ns/1ps
module mprc_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } mprc_sync_st_t;

   mprc_sync_st_t st;
   mprc_sync_st_t next_st;

   always_comb begin
      next_st        = st;
      next_st.stage1 = i_d;
      next_st.stage2 = st.stage1;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_q = st.stage2;
endmodule : mprc_sync

// ==== verilog/mprc_host_end.sv ====
// Host computer end: answers the boot request and drives its modem enable.
`timescale 1ns/1ps
module mprc_host_end (
   input  wire logic    I_REF_CLK,
   input  wire logic    I_RST,
   mprc_link_if.host    LINK,
   input  wire logic    i_HOST_MODEM_EN,
   output logic         o_HOST_RUNNING,
   output logic         o_BOOT_SEL_SEEN
);
   typedef struct packed {
      mprc_pkg::mprc_host_t                     state;
      logic [mprc_pkg::BOOT_CNT_W-1:0]          cnt;
      logic                                     modem_en;
      logic                                     boot_seen;
   } mprc_host_st_t;

   localparam logic [mprc_pkg::BOOT_CNT_W-1:0] BOOT_LAST =
      mprc_pkg::BOOT_CNT_W'(mprc_pkg::HOST_BOOT_CYC - 1);

   mprc_host_st_t st;
   mprc_host_st_t next_st;

   always_comb begin
      next_st          = st;
      next_st.modem_en = i_HOST_MODEM_EN;
      case (st.state)
         mprc_pkg::HOST_OFF: begin
            next_st.cnt = '0;
            if (LINK.host_power_on) begin
               next_st.state     = mprc_pkg::HOST_START;
               next_st.boot_seen = LINK.boot_sel;
            end
         end
         mprc_pkg::HOST_START: begin
            if (!LINK.host_power_on) begin
               next_st.state = mprc_pkg::HOST_OFF;
            end else if (st.cnt == BOOT_LAST) begin
               next_st.state = mprc_pkg::HOST_RUNNING; // R6
            end else begin
               next_st.cnt = st.cnt + 1'b1;
            end
         end
         mprc_pkg::HOST_RUNNING: begin
            if (!LINK.host_power_on) begin
               next_st.state = mprc_pkg::HOST_OFF;
            end
         end
         default: begin
            next_st.state = mprc_pkg::HOST_OFF;
         end
      endcase
   end

   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------------
   // Link outputs
   // ----------------------------------------------------------------------
   // Power good only once the start-up count has finished.
   assign LINK.host_power_good = (st.state == mprc_pkg::HOST_RUNNING); // R6
   assign LINK.host_status_on  = (st.state == mprc_pkg::HOST_RUNNING);
   assign LINK.host_modem_en   = st.modem_en;
   assign o_HOST_RUNNING       = (st.state == mprc_pkg::HOST_RUNNING);
   assign o_BOOT_SEL_SEEN      = st.boot_seen;
endmodule : mprc_host_end

// ==== verilog/mprc_dev_end.sv ====
// Module controller end: APB registers, modem supply select, host boot and serial routing.
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// R1 - Supply enables are active high.
// R2 - Host on: modem supply follows host line.
// R3 - Host off: modem supply follows micro line.
// R4 - Boost supply has no enable output here.
// R5 - Boot starts with boot select and power-on.
// R6 - Host running only after power good.
// R7 - Route micro to host before power-on.
// R8 - Three select outputs at bits two to four.
// R9 - Bit2 micro-host, bit3 modem-micro, bit4 modem-host.
// R10 - Monitor I2C addresses 0x45, 0x46, 0x47.
// R11 - Pre-regulator 0x48, GPS receiver 0x21.
// R12 - Calibration 31, 31 and 1024.
// R13 - Host serial 9600 GPS, 19200 modem.
// R14 - No select driven defaults to micro-modem.
// R15 - At most one select bit at once.
// R16 - Host inputs pass two synchroniser flip-flops.
module mprc_dev_end (
   input  wire logic        I_REF_CLK,
   input  wire logic        I_RST,
   mprc_link_if.dev         LINK,
   input  wire logic        i_PSEL,
   input  wire logic        i_PENABLE,
   input  wire logic        i_PWRITE,
   input  wire logic [11:0] i_PADDR,
   input  wire logic [31:0] i_PWDATA,
   output logic      [31:0] o_PRDATA,
   output logic             o_PREADY,
   output logic             o_PSLVERR,
   output logic             o_MODEM_PWR_EN,
   output logic       [4:0] o_PORT_SEL
);
   typedef struct packed {
      logic                 micro_modem_en;
      logic                 boot_sel_cfg;
      mprc_pkg::mprc_route_t route_cfg;
      mprc_pkg::mprc_boot_t  boot;
      mprc_pkg::mprc_route_t route;
      logic                 power_on;
      logic                 boot_sel;
      logic                 modem_pwr;
      logic [31:0]          rdata;
      logic                 slverr;
   } mprc_dev_st_t;

   mprc_dev_st_t st;
   mprc_dev_st_t next_st;
   logic   [2:0] host_sync;
   logic         host_on;
   logic         host_pgood;
   logic         host_modem;
   logic         apb_access;
   logic         hit_ctrl;
   logic         hit_stat;
   logic   [2:0] sel_vec;
   logic         rd_setup;
   logic         wr_ctrl;
   logic         boot_go;
   logic         host_off;

   // ----------------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------------
   mprc_sync #(
      .W (3)
   ) u_sync (
      .i_clk (I_REF_CLK),
      .i_rst (I_RST),
      .i_d   ({LINK.host_status_on, LINK.host_power_good, LINK.host_modem_en}),
      .o_q   (host_sync)
   ); // R16

   assign host_on    = host_sync[2];
   assign host_pgood = host_sync[1];
   assign host_modem = host_sync[0];

   // ----------------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------------
   assign apb_access = i_PSEL && i_PENABLE;
   assign hit_ctrl   = (i_PADDR == mprc_pkg::CTRL_OFS);
   assign hit_stat   = (i_PADDR == mprc_pkg::STATUS_OFS);
   assign rd_setup   = i_PSEL && !i_PENABLE;
   assign wr_ctrl    = apb_access && i_PWRITE && hit_ctrl;
   assign boot_go    = wr_ctrl && i_PWDATA[mprc_pkg::CTRL_BOOT_GO];
   assign host_off   = wr_ctrl && i_PWDATA[mprc_pkg::CTRL_HOST_OFF];

   // ----------------------------------------------------------------------
   // Routing select decode
   // ----------------------------------------------------------------------
   // A two-bit code can name only one pairing, so no two selects can ever meet.
   always_comb begin
      sel_vec = 3'b000;
      case (st.route)
         mprc_pkg::ROUTE_MICRO_HOST:  sel_vec = 3'b001; // R9
         mprc_pkg::ROUTE_MODEM_MICRO: sel_vec = 3'b010; // R9
         mprc_pkg::ROUTE_MODEM_HOST:  sel_vec = 3'b100; // R9
         mprc_pkg::ROUTE_NONE:        sel_vec = 3'b000; // R14
         default:                     sel_vec = 3'b000;
      endcase
   end // R15

   always_comb begin
      next_st        = st;
      next_st.rdata  = '0;
      next_st.slverr = 1'b0;

      // ---------------------------------------------------------------------
      // Register access
      // ---------------------------------------------------------------------
      // Read data are latched in the setup cycle, so every access ends without a wait state.
      if (rd_setup) begin
         if (!i_PWRITE && hit_ctrl) begin
            next_st.rdata[mprc_pkg::CTRL_MODEM_EN]  = st.micro_modem_en;
            next_st.rdata[mprc_pkg::CTRL_BOOT_SEL]  = st.boot_sel_cfg;
            next_st.rdata[mprc_pkg::CTRL_ROUTE_LSB +: 2] = st.route_cfg;
         end else if (!i_PWRITE && hit_stat) begin
            next_st.rdata[mprc_pkg::STAT_HOST_ON]    = host_on;
            next_st.rdata[mprc_pkg::STAT_POWER_GOOD] = host_pgood;
            next_st.rdata[mprc_pkg::STAT_MODEM_PWR]  = st.modem_pwr;
            next_st.rdata[mprc_pkg::STAT_SEL_LSB +: 3] = sel_vec;
            next_st.rdata[mprc_pkg::STAT_BOOT_LSB +: 2] = st.boot;
         end else if (!(i_PWRITE && hit_ctrl)) begin
            next_st.slverr = 1'b1;
         end
      end
      if (wr_ctrl) begin
         next_st.micro_modem_en = i_PWDATA[mprc_pkg::CTRL_MODEM_EN];
         next_st.boot_sel_cfg   = i_PWDATA[mprc_pkg::CTRL_BOOT_SEL];
         next_st.route_cfg      = mprc_pkg::mprc_route_t'(i_PWDATA[mprc_pkg::CTRL_ROUTE_LSB +: 2]);
      end

      // ---------------------------------------------------------------------
      // Modem supply select
      // ---------------------------------------------------------------------
      // The host's wish counts only once its status has passed the synchroniser.
      if (host_on) begin
         next_st.modem_pwr = host_modem; // R2
      end else begin
         next_st.modem_pwr = st.micro_modem_en; // R3
      end

      // ---------------------------------------------------------------------
      // Host boot sequence
      // ---------------------------------------------------------------------
      case (st.boot)
         mprc_pkg::BOOT_IDLE: begin
            next_st.power_on = 1'b0;
            next_st.route    = st.route_cfg;
            if (boot_go) begin
               next_st.route    = mprc_pkg::ROUTE_MICRO_HOST; // R7
               next_st.boot_sel = i_PWDATA[mprc_pkg::CTRL_BOOT_SEL]; // R5
               next_st.boot     = mprc_pkg::BOOT_ROUTE;
            end
         end
         mprc_pkg::BOOT_ROUTE: begin
            // The route has stood one full cycle before power-on rises.
            next_st.power_on = 1'b1; // R5
            next_st.boot     = mprc_pkg::BOOT_WAIT;
         end
         mprc_pkg::BOOT_WAIT: begin
            if (host_pgood) begin
               next_st.boot = mprc_pkg::BOOT_RUN; // R6
            end
         end
         mprc_pkg::BOOT_RUN: begin
            next_st.route = st.route_cfg;
         end
         default: begin
            next_st.boot = mprc_pkg::BOOT_IDLE;
         end
      endcase
      // Power-off wins over every busy state; boot select falls with power-on so that the
      // host never meets a stale boot choice at its next start.
      if (st.boot != mprc_pkg::BOOT_IDLE && host_off) begin
         next_st.boot     = mprc_pkg::BOOT_IDLE;
         next_st.power_on = 1'b0;
         next_st.boot_sel = 1'b0;
      end
   end

   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign o_PRDATA  = st.rdata;
   // No wait states: the read word already stands when the access phase begins.
   assign o_PREADY  = 1'b1;
   assign o_PSLVERR = st.slverr;

   // Only the modem supply enable is driven; the boost supply belongs to the modem.
   assign o_MODEM_PWR_EN = st.modem_pwr; // R1
   assign o_PORT_SEL     = {sel_vec, 2'b00}; // R8

   assign LINK.host_power_on   = st.power_on; // R1
   assign LINK.boot_sel        = st.boot_sel;
   assign LINK.sel_micro_host  = sel_vec[0];
   assign LINK.sel_modem_micro = sel_vec[1];
   assign LINK.sel_modem_host  = sel_vec[2];
endmodule : mprc_dev_end

// ==== tb/mprc_link_chk.sv ====
// Checker of the link between the controller end and the host end.
`timescale 1ns/1ps
module mprc_link_chk (
   input wire logic I_REF_CLK,
   input wire logic I_RST,
   input wire logic host_power_on,
   input wire logic boot_sel,
   input wire logic host_power_good,
   input wire logic host_status_on,
   input wire logic host_modem_en,
   input wire logic sel_micro_host,
   input wire logic sel_modem_micro,
   input wire logic sel_modem_host
);
   // ----
   // Timing window of the host boot
   // ----
   localparam int GOOD_MIN = 990;
   localparam int GOOD_MAX = 1010;
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (I_RST);
   logic [10:0] on_cnt;
   // The boot window is too long for a delay range, so the wait for power good is counted here.
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         on_cnt <= '0;
      end else if (!host_power_on) begin
         on_cnt <= '0;
      end else if (!host_power_good && on_cnt != 11'h7FF) begin
         on_cnt <= on_cnt + 11'h001;
      end
   end
   property p_one_sel;
      $onehot0({sel_micro_host, sel_modem_micro, sel_modem_host});
   endproperty
   a_one_sel: assert property (p_one_sel)
      else $error("more than one routing select high");
   property p_route_first;
      $rose(host_power_on) |-> $past(sel_micro_host) && sel_micro_host;
   endproperty
   a_route_first: assert property (p_route_first)
      else $error("power-on raised without micro-host routing");
   property p_route_hold;
      host_power_on && !host_power_good |-> sel_micro_host;
   endproperty
   a_route_hold: assert property (p_route_hold)
      else $error("routing left micro-host during boot");
   property p_good_delay;
      host_power_on && !host_power_good |-> on_cnt < GOOD_MAX;
   endproperty
   a_good_delay: assert property (p_good_delay)
      else $error("power good not seen in the boot window");
   property p_good_window;
      $rose(host_power_good) |-> on_cnt >= GOOD_MIN && on_cnt <= GOOD_MAX;
   endproperty
   a_good_window: assert property (p_good_window)
      else $error("power good outside the boot window");
   property p_good_quiet;
      $rose(host_power_on) |-> !host_power_good [*8];
   endproperty
   a_good_quiet: assert property (p_good_quiet)
      else $error("power good came too early");
   property p_good_needs_on;
      $rose(host_power_good) |-> host_power_on;
   endproperty
   a_good_needs_on: assert property (p_good_needs_on)
      else $error("power good without power-on");
   property p_status_good;
      host_status_on == host_power_good;
   endproperty
   a_status_good: assert property (p_status_good)
      else $error("host status differs from power good");
   property p_boot_sel_stable;
      host_power_on && $past(host_power_on) |-> $stable(boot_sel);
   endproperty
   a_boot_sel_stable: assert property (p_boot_sel_stable)
      else $error("boot select changed while powered");
   property p_off_drops_sel;
      $fell(host_power_on) |-> !boot_sel;
   endproperty
   a_off_drops_sel: assert property (p_off_drops_sel)
      else $error("boot select kept after power-off");
endmodule : mprc_link_chk

// ==== tb/modem_power_route_ctrl_tb_top.sv ====
// Self-checking testbench of both ends of the modem power route control.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module modem_power_route_ctrl_tb_top;
   logic        ref_clk;
   logic        rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic        pready;
   logic        pslverr;
   logic        err;
   logic        modem_pwr_en;
   logic [4:0]  port_sel;
   logic        hm_en;
   logic        host_running;
   logic        boot_seen;
   int          n_mismatch;
   int          n_compared;
   int          k;
   int          b0;
   int          e;
   int          exp_q[$];
   mprc_link_if link ();
   mprc_dev_end i_mprc_dev_end (.I_REF_CLK(ref_clk), .I_RST(rst), .LINK(link), .i_PSEL(psel),
      .i_PENABLE(penable), .i_PWRITE(pwrite), .i_PADDR(paddr), .i_PWDATA(pwdata),
      .o_PRDATA(prdata), .o_PREADY(pready), .o_PSLVERR(pslverr),
      .o_MODEM_PWR_EN(modem_pwr_en), .o_PORT_SEL(port_sel));
   mprc_host_end i_mprc_host_end (.I_REF_CLK(ref_clk), .I_RST(rst), .LINK(link),
      .i_HOST_MODEM_EN(hm_en), .o_HOST_RUNNING(host_running), .o_BOOT_SEL_SEEN(boot_seen));
   mprc_link_chk i_mprc_link_chk (.I_REF_CLK(ref_clk), .I_RST(rst),
      .host_power_on(link.host_power_on), .boot_sel(link.boot_sel),
      .host_power_good(link.host_power_good), .host_status_on(link.host_status_on),
      .host_modem_en(link.host_modem_en), .sel_micro_host(link.sel_micro_host),
      .sel_modem_micro(link.sel_modem_micro), .sel_modem_host(link.sel_modem_host));
   // ----
   // Model and bus tasks
   // ----
   function automatic logic [4:0] exp_sel(input int r);
      return (r == 0) ? 5'h00 : (5'h01 << (r + 1));
   endfunction : exp_sel
   function automatic logic exp_supply(input int on, input int host_line, input int micro_line);
      return (on != 0) ? host_line[0] : micro_line[0];
   endfunction : exp_supply
   task automatic summarize();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int w;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      for (w = 0; w < 50; w++) begin
         @(posedge ref_clk);
         if (pready === 1'b1) break;
      end
      if (w == 50) begin
         n_mismatch++;
         summarize();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : wait_cyc
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // ----
   // Main sequence
   // ----
   initial begin
      n_mismatch = 0;
      n_compared = 0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      hm_en = 1'b0;
      void'($urandom(30182));
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      @(negedge ref_clk);
      `CHK(port_sel, 5'h00)
      `CHK(modem_pwr_en, 1'b0)
      apb(1'b0, 12'h004, 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
      $display("reset test done");
      `CHK(mprc_pkg::I2C_ADDR_MON_5V, 7'h45)
      `CHK(mprc_pkg::I2C_ADDR_MON_BOOST, 7'h46)
      `CHK(mprc_pkg::I2C_ADDR_MON_GPS, 7'h47)
      `CHK(mprc_pkg::I2C_ADDR_MON_PREREG, 7'h48)
      `CHK(mprc_pkg::I2C_ADDR_GPS, 7'h21)
      `CHK(mprc_pkg::CAL_MON_5V, 16'h001F)
      `CHK(mprc_pkg::CAL_MON_BOOST, 16'h001F)
      `CHK(mprc_pkg::CAL_MON_GPS, 16'h0400)
      `CHK(mprc_pkg::BAUD_GPS, 32'h0000_2580)
      `CHK(mprc_pkg::BAUD_MODEM, 32'h0000_4B00)
      $display("constant test done");
      for (k = 0; k < 4; k++) begin
         apb(1'b1, 12'h000, 32'(k << 2));
         wait_cyc(2);
         `CHK(port_sel, exp_sel(k))
         `CHK({link.sel_modem_host, link.sel_modem_micro, link.sel_micro_host}, port_sel[4:2])
         apb(1'b0, 12'h000, 32'h0000_0000);
         `CHK(rd, 32'(k << 2))
      end
      $display("routing test done");
      for (k = 0; k < 6; k++) begin
         b0 = $urandom % 2;
         e = $urandom % 2;
         @(posedge ref_clk);
         hm_en <= e[0];
         exp_q.push_back(exp_supply(0, e, b0));
         apb(1'b1, 12'h000, 32'(b0));
         wait_cyc(4);
         e = exp_q.pop_front();
         `CHK(modem_pwr_en, e[0])
         apb(1'b0, 12'h004, 32'h0000_0000);
         `CHK(rd[2], b0[0])
      end
      $display("local supply test done");
      apb(1'b0, 12'h008, 32'h0000_0000);
      `CHK({err, rd}, {1'b1, 32'h0000_0000})
      apb(1'b1, 12'h004, 32'h0000_0010);
      `CHK(err, 1'b1)
      apb(1'b1, 12'h010, 32'h0000_0010);
      wait_cyc(3);
      `CHK(link.host_power_on, 1'b0)
      $display("refusal test done");
      apb(1'b1, 12'h000, 32'h0000_001E);
      wait_cyc(2);
      `CHK(port_sel, 5'h04)
      `CHK(link.boot_sel, 1'b1)
      wait_cyc(1);
      `CHK(link.host_power_on, 1'b1)
      for (k = 0; k < 700; k++) begin
         apb(1'b0, 12'h004, 32'h0000_0000);
         if (rd[7:6] === 2'b11) break;
         `CHK(rd[5:3], 3'h1)
      end
      if (k == 700) begin
         n_mismatch++;
         summarize();
      end
      wait_cyc(1);
      `CHK(port_sel, exp_sel(3))
      `CHK({host_running, boot_seen}, 2'b11)
      `CHK(port_sel[1:0], 2'h0)
      for (k = 0; k < 6; k++) begin
         b0 = $urandom % 2;
         @(posedge ref_clk);
         hm_en <= b0[0];
         exp_q.push_back(exp_supply(1, b0, 1 - b0));
         apb(1'b1, 12'h000, 32'(32'h0000_000C | (1 - b0)));
         wait_cyc(6);
         e = exp_q.pop_front();
         `CHK(modem_pwr_en, e[0])
      end
      $display("boot test done");
      @(posedge ref_clk);
      hm_en <= 1'b1;
      apb(1'b1, 12'h000, 32'h0000_0020);
      wait_cyc(10);
      `CHK({link.host_power_on, host_running}, 2'b00)
      `CHK(port_sel, 5'h00)
      `CHK(modem_pwr_en, 1'b0)
      $display("host off test done");
      summarize();
   end
endmodule : modem_power_route_ctrl_tb_top
